// *** verilog/eims_exec.sv ***
// execution unit: extended increments, invert, move, multi save/restore
// assumes an apb master and a data memory that acks one request at a time
//
// How it works
// - increment by one writes back sum
// - zero and carry set from all-ones input
// - overflow set from largest positive input
// - increment by two writes back sum
// - zero set from all-ones minus one
// - carry set from two highest values
// - overflow set from two largest positives
// - negative follows result msb at width
// - invert complements all bits at width
// - invert flags: c=!z, z, v from sign
// - move copies, flags and source untouched
// - mode bits changed by these ops only when the status register is the destination
// - address-word restore: four per register, ascending
// - word restore: two per register, clear top
// - restore leaves flags unless status register restored
// - address-word save downward, upper bits higher
// - word save downward, two per register
// - saved registers keep their full contents
// - multi ops need no extension word
module eims_exec
  import eims_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [19:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic      [1:0]  mem_be,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_LO, ST_RD_HI, ST_EXEC, ST_WR_LO, ST_WR_HI,
    ST_PUSH_HI, ST_PUSH_LO, ST_POP_LO, ST_POP_HI
  } eims_state_t;

  typedef struct packed {
    eims_state_t       st;
    logic [15:0][19:0] regs;
    logic [2:0]        op;
    logic [1:0]        wid;
    logic              dmem;
    logic              maw;
    logic [3:0]        sreg;
    logic [3:0]        idx;
    logic [3:0]        cnt;
    logic [19:0]       src_addr;
    logic [19:0]       dst_addr;
    logic [19:0]       rd_addr;
    logic [1:0]        ext_wid;
    logic              ext_armed;
    logic [19:0]       opnd;
    logic [19:0]       res;
    logic [3:0]        nzcv;
    logic              done;
    logic              cmd_err;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              mem_req;
    logic              mem_we;
    logic [19:0]       mem_addr;
    logic [15:0]       mem_wdata;
    logic [1:0]        mem_be;
  } eims_regs_t;

  eims_regs_t  s;
  eims_regs_t  next_s;

  logic [19:0] alu_res;
  logic        alu_n;
  logic        alu_z;
  logic        alu_c;
  logic        alu_v;
  logic        apb_go;
  logic        busy;
  logic [19:0] sp;
  logic [15:0] rd_lane;
  logic [2:0]  c_op;
  logic [3:0]  c_cnt;
  logic [3:0]  c_dreg;
  logic [19:0] wval;

  eims_alu u_alu (
    .op   (s.op),
    .wid  (s.wid),
    .opnd (s.opnd),
    .res  (alu_res),
    .fl_n (alu_n),
    .fl_z (alu_z),
    .fl_c (alu_c),
    .fl_v (alu_v)
  );

  // status register with new arithmetic flags, mode bits kept
  function automatic logic [19:0] sr_flags(input logic [19:0] sr,
                                           input logic [3:0]  f);
    logic [19:0] r;
    r       = sr;
    r[SR_N] = f[3];
    r[SR_Z] = f[2];
    r[SR_C] = f[1];
    r[SR_V] = f[0];
    return r;
  endfunction

  // restored value; the status register keeps its mode bits
  function automatic logic [19:0] pop_val(input logic [3:0]  r,
                                          input logic [19:0] v,
                                          input logic [19:0] old);
    if (r == REG_SR) begin
      return (v & ~SR_MODE) | (old & SR_MODE);
    end
    return v;
  endfunction

  always_comb begin
    next_s  = s;
    apb_go  = psel && penable && !s.pready;
    busy    = (s.st != ST_IDLE);
    sp      = s.regs[REG_SP];
    rd_lane = mem_rdata;
    c_op    = pwdata[CMD_OP +: 3];
    c_cnt   = pwdata[CMD_CNT +: 4];
    c_dreg  = pwdata[CMD_DREG +: 4];
    wval    = 20'h0_0000;
    if (s.wid == WID_BYTE && s.rd_addr[0]) begin
      rd_lane = {8'h00, mem_rdata[15:8]};
    end else if (s.wid == WID_BYTE) begin
      rd_lane = {8'h00, mem_rdata[7:0]};
    end

    // apb slave: one wait state, answer pready for one cycle
    next_s.pready  = apb_go;
    next_s.pslverr = 1'b0;
    if (apb_go && !pwrite) begin
      next_s.prdata = 32'h0000_0000;
      if (paddr == ADDR_EXT) begin
        next_s.prdata[EXT_WID +: 2] = s.ext_wid;
      end else if (paddr == ADDR_SRC) begin
        next_s.prdata[19:0] = s.src_addr;
      end else if (paddr == ADDR_DST) begin
        next_s.prdata[19:0] = s.dst_addr;
      end else if (paddr == ADDR_STAT) begin
        next_s.prdata[STAT_DONE] = s.done;
        next_s.prdata[STAT_BUSY] = busy;
        next_s.prdata[STAT_ARM]  = s.ext_armed;
        next_s.prdata[STAT_ERR]  = s.cmd_err;
      end else if (paddr >= ADDR_REGS && paddr <= ADDR_REGE
                   && paddr[1:0] == 2'h0) begin
        next_s.prdata[19:0] = s.regs[paddr[5:2]];
      end else if (paddr != ADDR_CMD) begin
        next_s.pslverr = 1'b1;
      end
    end else if (apb_go) begin
      if (busy && paddr != ADDR_STAT) begin
        next_s.pslverr = 1'b1;
      end else if (paddr == ADDR_EXT) begin
        next_s.ext_wid   = pwdata[EXT_WID +: 2];
        next_s.ext_armed = (pwdata[EXT_WID +: 2] != 2'h3);
      end else if (paddr == ADDR_SRC) begin
        next_s.src_addr = pwdata[19:0];
      end else if (paddr == ADDR_DST) begin
        next_s.dst_addr = pwdata[19:0];
      end else if (paddr >= ADDR_REGS && paddr <= ADDR_REGE
                   && paddr[1:0] == 2'h0) begin
        next_s.regs[paddr[5:2]] = pwdata[19:0];
      end else if (paddr == ADDR_CMD) begin
        next_s.op      = c_op;
        next_s.dmem    = pwdata[CMD_DMEM];
        next_s.sreg    = pwdata[CMD_SREG +: 4];
        next_s.idx     = c_dreg;
        next_s.cnt     = c_cnt;
        next_s.maw     = pwdata[CMD_MAW];
        next_s.done    = 1'b0;
        next_s.cmd_err = 1'b0;
        if (c_op == OPC_MSAVE || c_op == OPC_MREST) begin
          // width comes from the command word alone
          next_s.wid = pwdata[CMD_MAW] ? WID_ADDR : WID_WORD;
          if (c_op == OPC_MSAVE) begin
            next_s.st = pwdata[CMD_MAW] ? ST_PUSH_HI : ST_PUSH_LO;
          end else begin
            next_s.idx = c_dreg - c_cnt;
            next_s.st  = ST_POP_LO;
          end
        end else if (c_op >= OPC_INC1 && c_op <= OPC_MOVE
                     && s.ext_armed) begin
          next_s.wid       = s.ext_wid;
          next_s.ext_armed = 1'b0;
          if (c_op == OPC_MOVE && pwdata[CMD_SMEM]) begin
            next_s.rd_addr = s.src_addr;
            next_s.st      = ST_RD_LO;
          end else if (c_op != OPC_MOVE && pwdata[CMD_DMEM]) begin
            next_s.rd_addr = s.dst_addr;
            next_s.st      = ST_RD_LO;
          end else begin
            next_s.opnd = (c_op == OPC_MOVE)
                        ? s.regs[pwdata[CMD_SREG +: 4]]
                        : s.regs[c_dreg];
            next_s.st   = ST_EXEC;
          end
        end else begin
          next_s.cmd_err = 1'b1;
        end
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    // sequencer
    unique case (s.st)
      ST_IDLE: begin
      end
      ST_RD_LO, ST_RD_HI: begin
        if (!s.mem_req) begin
          next_s.mem_req  = 1'b1;
          next_s.mem_we   = 1'b0;
          next_s.mem_be   = 2'h3;
          next_s.mem_addr = (s.st == ST_RD_HI)
                          ? s.rd_addr + STEP_HALF : s.rd_addr;
        end else if (mem_ack) begin
          next_s.mem_req = 1'b0;
          if (s.st == ST_RD_HI) begin
            next_s.opnd[19:16] = mem_rdata[3:0];
            next_s.st          = ST_EXEC;
          end else begin
            next_s.opnd = {4'h0, rd_lane};
            next_s.st   = (s.wid == WID_ADDR) ? ST_RD_HI : ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        next_s.res  = alu_res;
        next_s.nzcv = {alu_n, alu_z, alu_c, alu_v};
        if (s.dmem) begin
          next_s.st = ST_WR_LO;
        end else begin
          next_s.regs[s.idx] = alu_res;
          if (s.op != OPC_MOVE) begin
            // flags and register land on the same edge
            next_s.regs[REG_SR] = sr_flags(
              (s.idx == REG_SR) ? alu_res : s.regs[REG_SR],
              {alu_n, alu_z, alu_c, alu_v});
          end
          next_s.done = 1'b1;
          next_s.st   = ST_IDLE;
        end
      end
      ST_WR_LO, ST_WR_HI: begin
        if (!s.mem_req) begin
          next_s.mem_req = 1'b1;
          next_s.mem_we  = 1'b1;
          if (s.st == ST_WR_HI) begin
            next_s.mem_addr  = s.dst_addr + STEP_HALF;
            next_s.mem_wdata = {12'h000, s.res[19:16]};
            next_s.mem_be    = 2'h3;
          end else if (s.wid == WID_BYTE) begin
            next_s.mem_addr  = s.dst_addr;
            next_s.mem_wdata = {s.res[7:0], s.res[7:0]};
            next_s.mem_be    = s.dst_addr[0] ? 2'h2 : 2'h1;
          end else begin
            next_s.mem_addr  = s.dst_addr;
            next_s.mem_wdata = s.res[15:0];
            next_s.mem_be    = 2'h3;
          end
        end else if (mem_ack) begin
          next_s.mem_req = 1'b0;
          if (s.st == ST_WR_LO && s.wid == WID_ADDR) begin
            next_s.st = ST_WR_HI;
          end else begin
            if (s.op != OPC_MOVE) begin
              next_s.regs[REG_SR] = sr_flags(s.regs[REG_SR],
                                             s.nzcv);
            end
            next_s.done = 1'b1;
            next_s.st   = ST_IDLE;
          end
        end
      end
      ST_PUSH_HI, ST_PUSH_LO: begin
        // saved register contents are only read here; only the stack pointer register is written
        if (!s.mem_req) begin
          next_s.mem_req  = 1'b1;
          next_s.mem_we   = 1'b1;
          next_s.mem_be   = 2'h3;
          next_s.mem_addr = sp - STEP_HALF;
          next_s.mem_wdata = (s.st == ST_PUSH_HI)
                           ? {12'h000, s.regs[s.idx][19:16]}
                           : s.regs[s.idx][15:0];
        end else if (mem_ack) begin
          next_s.mem_req      = 1'b0;
          next_s.regs[REG_SP] = sp - STEP_HALF;
          if (s.st == ST_PUSH_HI) begin
            next_s.st = ST_PUSH_LO;
          end else if (s.cnt == 4'h0) begin
            next_s.done = 1'b1;
            next_s.st   = ST_IDLE;
          end else begin
            next_s.cnt = s.cnt - 4'h1;
            next_s.idx = s.idx - 4'h1;
            next_s.st  = s.maw ? ST_PUSH_HI : ST_PUSH_LO;
          end
        end
      end
      ST_POP_LO, ST_POP_HI: begin
        if (!s.mem_req) begin
          next_s.mem_req  = 1'b1;
          next_s.mem_we   = 1'b0;
          next_s.mem_be   = 2'h3;
          next_s.mem_addr = sp;
        end else if (mem_ack) begin
          next_s.mem_req      = 1'b0;
          next_s.regs[REG_SP] = sp + STEP_HALF;
          if (s.st == ST_POP_LO && s.maw) begin
            next_s.opnd = {4'h0, mem_rdata};
            next_s.st   = ST_POP_HI;
          end else begin
            wval = (s.st == ST_POP_HI)
                 ? {mem_rdata[3:0], s.opnd[15:0]}
                 : {4'h0, mem_rdata};
            next_s.regs[s.idx] = pop_val(s.idx, wval,
                                         s.regs[s.idx]);
            if (s.cnt == 4'h0) begin
              next_s.done = 1'b1;
              next_s.st   = ST_IDLE;
            end else begin
              next_s.cnt = s.cnt - 4'h1;
              next_s.idx = s.idx + 4'h1;
              next_s.st  = ST_POP_LO;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.regs <= {16{RST_REG}};
    end else begin
      s <= next_s;
    end
  end

  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign mem_req   = s.mem_req;
  assign mem_we    = s.mem_we;
  assign mem_addr  = s.mem_addr;
  assign mem_wdata = s.mem_wdata;
  assign mem_be    = s.mem_be;

endmodule // eims_exec

// *** include/eims_pkg.sv ***
// constants, field layouts and width helpers for the extended execution unit
// assumes a 32-bit apb slave and a 16-bit data memory behind one clock
package eims_pkg;

  localparam int XLEN = 20;

  // register byte offsets
  localparam logic [11:0] ADDR_CMD  = 12'h000;
  localparam logic [11:0] ADDR_EXT  = 12'h004;
  localparam logic [11:0] ADDR_SRC  = 12'h008;
  localparam logic [11:0] ADDR_DST  = 12'h00c;
  localparam logic [11:0] ADDR_STAT = 12'h010;
  localparam logic [11:0] ADDR_REGS = 12'h040;
  localparam logic [11:0] ADDR_REGE = 12'h07c;

  // command word fields
  localparam int CMD_OP   = 0;
  localparam int CMD_DMEM = 3;
  localparam int CMD_SMEM = 4;
  localparam int CMD_SREG = 5;
  localparam int CMD_DREG = 9;
  localparam int CMD_CNT  = 13;
  localparam int CMD_MAW  = 17;

  // extension word and status fields
  localparam int EXT_WID   = 0;
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_ARM  = 2;
  localparam int STAT_ERR  = 3;

  // operation codes
  localparam logic [2:0] OPC_INC1  = 3'h1;
  localparam logic [2:0] OPC_INC2  = 3'h2;
  localparam logic [2:0] OPC_INV   = 3'h3;
  localparam logic [2:0] OPC_MOVE  = 3'h4;
  localparam logic [2:0] OPC_MSAVE = 3'h5;
  localparam logic [2:0] OPC_MREST = 3'h6;

  // operand widths
  localparam logic [1:0] WID_BYTE = 2'h0;
  localparam logic [1:0] WID_WORD = 2'h1;
  localparam logic [1:0] WID_ADDR = 2'h2;

  // register file roles and status register bits
  localparam logic [3:0] REG_SP   = 4'h1;
  localparam logic [3:0] REG_SR   = 4'h2;
  localparam int         SR_C     = 0;
  localparam int         SR_Z     = 1;
  localparam int         SR_N     = 2;
  localparam int         SR_V     = 8;
  localparam logic [19:0] SR_MODE = 20'h0_0038;
  localparam logic [19:0] RST_REG = 20'h0_0000;

  // stack steps
  localparam logic [19:0] STEP_HALF = 20'h0_0002;

  function automatic logic [19:0] wid_mask(input logic [1:0] w);
    unique case (w)
      WID_BYTE: wid_mask = 20'h0_00ff;
      WID_WORD: wid_mask = 20'h0_ffff;
      default:  wid_mask = 20'hf_ffff;
    endcase
  endfunction

  function automatic logic wid_msb(input logic [19:0] v,
                                   input logic [1:0]  w);
    unique case (w)
      WID_BYTE: wid_msb = v[7];
      WID_WORD: wid_msb = v[15];
      default:  wid_msb = v[19];
    endcase
  endfunction

endpackage

// *** verilog/eims_alu.sv ***
// increment, double-increment, invert and move datapath with flags
// masks the incoming operand to the chosen width itself
module eims_alu
  import eims_pkg::*;
(
  input  wire logic [2:0]  op,
  input  wire logic [1:0]  wid,
  input  wire logic [19:0] opnd,
  output logic      [19:0] res,
  output logic             fl_n,
  output logic             fl_z,
  output logic             fl_c,
  output logic             fl_v
);

  logic [19:0] mask;
  logic [19:0] pmax;
  logic [19:0] d;

  always_comb begin
    mask = wid_mask(wid);
    pmax = mask >> 1;
    d    = opnd & mask;
    res  = d;
    fl_z = 1'b0;
    fl_c = 1'b0;
    fl_v = 1'b0;
    unique case (op)
      OPC_INC1: begin
        res  = (d + 20'h0_0001) & mask;
        fl_z = (d == mask);
        fl_c = (d == mask);
        fl_v = (d == pmax);
      end
      OPC_INC2: begin
        res  = (d + 20'h0_0002) & mask;
        fl_z = (d == mask - 20'h0_0001);
        fl_c = (d >= mask - 20'h0_0001);
        fl_v = (d == pmax) || (d == pmax - 20'h0_0001);
      end
      OPC_INV: begin
        res  = d ^ mask;
        fl_z = (d == mask);
        fl_c = (d != mask);
        fl_v = wid_msb(d, wid);
      end
      default: res = d;
    endcase
    fl_n = wid_msb(res, wid);
  end

endmodule // eims_alu

// *** bench/eims_exec_asserts.sv ***
// port checker for the extended execution unit
// assumes binding to eims_exec, one clock, async active-low reset
module eims_exec_asserts
  import eims_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0]  mem_be,
  input wire logic [15:0] mem_rdata,
  input wire logic        mem_ack
);
  logic [2:0]  op_q;
  logic [19:0] last_a;
  logic        have;
  wire         cmd_ok = psel && penable && pready && pwrite && !pslverr &&
                        paddr == ADDR_CMD;
  // remembers the running op and the previous memory address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q   <= 3'h0;
      have   <= 1'b0;
      last_a <= 20'h0_0000;
    end else if (cmd_ok) begin
      op_q <= pwdata[2:0];
      have <= 1'b0;
    end else if (mem_ack) begin
      last_a <= mem_addr;
      have   <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we) && $stable(mem_be))
    else $error("memory request changed before ack");
  AST_REQ_GAP: assert property (mem_ack |=> !mem_req)
    else $error("memory request not dropped after ack");
  AST_SAVE_DOWN: assert property (op_q == OPC_MSAVE && mem_req |->
    mem_we && (!have || mem_addr == last_a - STEP_HALF))
    else $error("multi save not writing downward by two");
  AST_REST_UP: assert property (op_q == OPC_MREST && mem_req |->
    !mem_we && (!have || mem_addr == last_a + STEP_HALF))
    else $error("multi restore not reading upward by two");
  AST_DONE_IDLE: assert property (psel && pready && !pwrite &&
    paddr == ADDR_STAT && prdata[STAT_DONE] |-> !mem_req)
    else $error("done reported with memory traffic pending");
  AST_BUSY_REFUSE: assert property (psel && pready && pwrite &&
    paddr == ADDR_CMD && mem_req |-> pslverr)
    else $error("command accepted while busy");
  cover property (op_q == OPC_MSAVE && mem_ack);
  cover property (op_q == OPC_MREST && mem_ack);
  cover property (psel && pready && pslverr);
endmodule // eims_exec_asserts

bind eims_exec eims_exec_asserts i_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack));

// *** bench/eims_mem.sv ***
// data memory partner: 16-bit words, acks after lat extra cycles
// assumes the execution unit's memory port on the same clock
module eims_mem
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [19:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [1:0]  mem_be,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] m [4096];
  int          lat = 1;
  int          cnt;
  // read data is only valid with ack; it toggles otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      cnt       <= 0;
      mem_rdata <= 16'h0000;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (cnt < lat) begin
          cnt <= cnt + 1;
        end else begin
          cnt       <= 0;
          mem_ack   <= 1'b1;
          mem_rdata <= m[mem_addr[12:1]];
          if (mem_we && mem_be[0]) m[mem_addr[12:1]][7:0] <= mem_wdata[7:0];
          if (mem_we && mem_be[1]) m[mem_addr[12:1]][15:8] <= mem_wdata[15:8];
        end
      end
    end
  end
endmodule // eims_mem

// *** bench/test_extended_incr_move_stack_exec.sv ***
// self-checking bench for the extended execution unit
// assumes eims_exec, the eims_mem partner and the bound checker
module test_extended_incr_move_stack_exec
  import eims_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv;
  logic        pready, pslverr, mem_req, mem_we, mem_ack, erv;
  logic [19:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [1:0]  mem_be;
  int          n_fail = 0, comparisons = 0;
  always #50 pclk = ~pclk;
  eims_exec i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  eims_mem u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_be(mem_be), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_fail++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [11:0] ra(input int i);
    return ADDR_REGS + 12'(4 * i);
  endfunction
  function automatic logic [31:0] mk(input logic [2:0] op, input logic dm,
    input logic sm, input logic [3:0] s, input logic [3:0] d,
    input logic [3:0] n1, input logic maw);
    mk = '0;
    mk[CMD_OP+:3] = op;
    mk[CMD_DMEM] = dm;
    mk[CMD_SMEM] = sm;
    mk[CMD_SREG+:4] = s;
    mk[CMD_DREG+:4] = d;
    mk[CMD_CNT+:4] = n1;
    mk[CMD_MAW] = maw;
  endfunction
  task automatic wait_done;
    int k;
    k = 0;
    do begin
      apb(0, ADDR_STAT, '0);
      k++;
    end while (rdv[STAT_DONE] !== 1'b1 && k < 100);
    chk("done", 32'h1, {31'h0, rdv[STAT_DONE]});
  endtask
  task automatic run(input logic [31:0] c);
    apb(1, ADDR_CMD, c);
    wait_done;
  endtask
  task automatic t_arith;
    logic [2:0] ops [3];
    logic [19:0] m, o, r, h, sg, x;
    logic z, c, v;
    ops = '{OPC_INC1, OPC_INC2, OPC_INV};
    for (int i = 0; i < 3; i++) for (int w = 0; w < 3; w++)
      for (int k = 0; k < 5; k++) begin
        m = (w == 0) ? 20'h0_00ff : (w == 1) ? 20'h0_ffff : 20'hf_ffff;
        h = m >> 1;
        sg = m ^ h;
        o = (k == 0) ? m : (k == 1) ? m - 1 : (k == 2) ? h : (k == 3) ? h - 1 : '0;
        if (ops[i] == OPC_INV) begin
          r = o ^ m;
          z = (o == m);
          c = !z;
          v = |(o & sg);
        end else if (ops[i] == OPC_INC1) begin
          r = (o + 1) & m;
          z = (o == m);
          c = z;
          v = (o == h);
        end else begin
          r = (o + 2) & m;
          z = (o == m - 1);
          c = (o >= m - 1);
          v = (o == h) || (o == h - 1);
        end
        x = SR_MODE;
        x[SR_C] = c;
        x[SR_Z] = z;
        x[SR_V] = v;
        x[SR_N] = |(r & sg);
        apb(1, ADDR_EXT, 32'(w));
        apb(1, ra(5), {12'h0, o | (20'ha_5a5a & ~m)});
        apb(1, ra(2), {12'h0, SR_MODE});
        run(mk(ops[i], 0, 0, 0, 5, 0, 0));
        apb(0, ra(5), '0);
        chk("result", {12'h0, r}, rdv);
        apb(0, ra(2), '0);
        chk("flags", {12'h0, x}, rdv);
      end
  endtask
  task automatic t_mem;
    u_mem.lat = 6;
    u_mem.m[128] = 16'hffff;
    u_mem.m[129] = 16'h000f;
    apb(1, ADDR_EXT, {30'h0, WID_ADDR});
    apb(1, ADDR_DST, 32'h0000_0100);
    apb(1, ra(2), '0);
    apb(1, ADDR_CMD, mk(OPC_INC1, 1, 0, 0, 0, 0, 0));
    apb(1, ADDR_CMD, mk(OPC_INC1, 1, 0, 0, 0, 0, 0));
    chk("busy refusal", 32'h1, {31'h0, erv});
    wait_done;
    u_mem.lat = 1;
    chk("mem low", 32'h0, {16'h0, u_mem.m[128]});
    chk("mem high", 32'h0, {28'h0, u_mem.m[129][3:0]});
    apb(0, ra(2), '0);
    chk("mem flags", 32'h0000_0003, rdv);
  endtask
  task automatic t_move;
    apb(1, ra(2), 32'h0000_013f);
    u_mem.m[256] = 16'hbeef;
    u_mem.m[384] = 16'h1234;
    apb(1, ADDR_EXT, {30'h0, WID_BYTE});
    apb(1, ADDR_SRC, 32'h0000_0201);
    apb(1, ADDR_DST, 32'h0000_0300);
    run(mk(OPC_MOVE, 1, 1, 0, 0, 0, 0));
    chk("byte dst", 32'h0000_12be, {16'h0, u_mem.m[384]});
    chk("byte src", 32'h0000_beef, {16'h0, u_mem.m[256]});
    apb(1, ADDR_EXT, {30'h0, WID_ADDR});
    apb(1, ra(6), 32'h0005_cafe);
    apb(1, ADDR_DST, 32'h0000_0302);
    run(mk(OPC_MOVE, 1, 0, 6, 0, 0, 0));
    chk("aw low", 32'h0000_cafe, {16'h0, u_mem.m[385]});
    chk("aw high", 32'h5, {28'h0, u_mem.m[386][3:0]});
    apb(0, ra(6), '0);
    chk("src reg", 32'h0005_cafe, rdv);
    apb(0, ra(2), '0);
    chk("move flags", 32'h0000_013f, rdv);
  endtask
  task automatic t_stack;
    logic [19:0] v;
    apb(1, ADDR_EXT, 32'h0000_0003);
    apb(1, ra(4), 32'h0000_0009);
    apb(1, ADDR_CMD, mk(OPC_INC1, 0, 0, 0, 4, 0, 0));
    apb(0, ADDR_STAT, '0);
    chk("unarmed", 32'h1, {31'h0, rdv[STAT_ERR]});
    apb(0, 12'h020, '0);
    chk("unmapped", 32'h1, {rdv[30:0], erv});
    apb(1, ra(1), 32'h0000_0400);
    apb(1, ra(2), {12'h0, SR_MODE});
    for (int i = 4; i < 8; i++) apb(1, ra(i), {12'h0, 20'h1_1111 * 20'(i)});
    run(mk(OPC_MSAVE, 0, 0, 0, 7, 3, 1));
    apb(0, ra(1), '0);
    chk("sp save a", 32'h0000_03f0, rdv);
    for (int i = 4; i < 8; i++) begin
      v = 20'h1_1111 * 20'(i);
      chk("low", {16'h0, v[15:0]}, {16'h0, u_mem.m[504 + 2 * (i - 4)]});
      chk("high", {28'h0, v[19:16]}, {28'h0, u_mem.m[505 + 2 * (i - 4)][3:0]});
      apb(0, ra(i), '0);
      chk("kept", {12'h0, v}, rdv);
      apb(1, ra(i), '0);
    end
    run(mk(OPC_MREST, 0, 0, 0, 7, 3, 1));
    for (int i = 4; i < 8; i++) begin
      apb(0, ra(i), '0);
      chk("restored", {12'h0, 20'h1_1111 * 20'(i)}, rdv);
    end
    apb(0, ra(1), '0);
    chk("sp rest a", 32'h0000_0400, rdv);
    apb(0, ra(2), '0);
    chk("sr kept", {12'h0, SR_MODE}, rdv);
    run(mk(OPC_MSAVE, 0, 0, 0, 6, 1, 0));
    chk("w hi", 32'h0000_6666, {16'h0, u_mem.m[511]});
    chk("w lo", 32'h0000_5555, {16'h0, u_mem.m[510]});
    apb(1, ra(5), '0);
    apb(1, ra(6), '0);
    run(mk(OPC_MREST, 0, 0, 0, 6, 1, 0));
    apb(0, ra(5), '0);
    chk("w rest", 32'h0000_5555, rdv);
    apb(0, ra(1), '0);
    chk("sp rest w", 32'h0000_0400, rdv);
    u_mem.m[512] = 16'h0107;
    run(mk(OPC_MREST, 0, 0, 0, 2, 0, 0));
    apb(0, ra(2), '0);
    chk("sr popped", 32'h0000_013f, rdv);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ra(5), '0);
    chk("reset reg", 32'h0, rdv);
    t_arith;
    t_mem;
    t_move;
    t_stack;
    complete_run;
  end
  initial begin
    #(20000 * 100);
    n_fail++;
    complete_run;
  end
endmodule // test_extended_incr_move_stack_exec
